// ---- common/safety_sup_pkg.sv ----
package safety_sup_pkg;

   // ==========================================================
   // timing
   localparam int CLK_MHZ = 250;
   localparam int BEAM_RESP_MS = 20;
   localparam int LOCK_RESP_MS = 500;
   localparam int DEBOUNCE_US = 1000;
   localparam int FB_SETTLE_MS = 300;
   localparam int BEAM_RESP_CYC = BEAM_RESP_MS * 1000 * CLK_MHZ;
   localparam int LOCK_RESP_CYC = LOCK_RESP_MS * 1000 * CLK_MHZ;
   localparam int DEB_CYC = DEBOUNCE_US * CLK_MHZ;
   localparam int FB_CYC = FB_SETTLE_MS * 1000 * CLK_MHZ;
   localparam int START_EXTRA = 4;

   // ==========================================================
   // contact inputs, 1 = contact closed / condition true
   localparam int IN_BEAM = 0;
   localparam int IN_FAULT = 1;
   localparam int IN_RELEASE = 2;
   localparam int IN_EXTLOCK = 3;
   localparam int IN_FORCEOFF = 4;
   localparam int IN_MUTE_A = 5;
   localparam int IN_MUTE_B = 6;
   localparam int IN_TEST = 7;
   localparam int IN_RESTART = 8;
   localparam int IN_FB_A = 9;
   localparam int IN_FB_B = 10;
   localparam int NUM_IN = 11;

   typedef struct packed {
      logic fb_b;
      logic fb_a;
      logic restart;
      logic test;
      logic mute_b;
      logic mute_a;
      logic force_off;
      logic ext_lock;
      logic release_req;
      logic fault;
      logic beam_ok;
   } contacts_s;

   typedef struct packed {
      logic power;
      logic beam;
      logic out_off;
      logic lockout;
   } leds_s;

   // ==========================================================
   // register map
   localparam int AW = 12;
   localparam logic [AW-1:0] ADDR_CTRL = 12'h000;
   localparam logic [AW-1:0] ADDR_STATUS = 12'h004;
   localparam int CB_MUTE = 0;
   localparam int CB_TEST = 1;
   localparam int CB_RESTART = 2;
   localparam int CB_MONITOR = 3;
   localparam int CB_TRI_LED = 4;
   localparam int CTRL_W = 5;
   localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
   localparam int SB_SAFE = 0;
   localparam int SB_LOCK = 2;
   localparam int SB_VALID = 3;
   localparam int SB_MUTED = 4;
   localparam int SB_FB_ERR = 5;
   localparam int SB_EXT_CAUSE = 6;
   localparam int SB_IN_LSB = 16;

endpackage

// ---- logic/light_curtain_safety_supervisor.sv ----
module light_curtain_safety_supervisor
   import safety_sup_pkg::*;
#(
   parameter int DEB_CYC_P = DEB_CYC,
   parameter int FB_CYC_P = FB_CYC
) (
   // clock, reset, enable
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [AW-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // contact and sensor inputs
   input wire contacts_s CONTACT_I,
   // relays, emitter, indicators
   output logic [1:0] SAFETY_OUT_O,
   output logic LOCKOUT_OUT_O,
   output logic MONITOR_OUT_O,
   output logic EMIT_EN_O,
   output leds_s LED_O
);

   localparam int START_CYC = DEB_CYC_P + START_EXTRA;
   localparam int DCW = $clog2(DEB_CYC_P + 1);
   localparam int FCW = $clog2(FB_CYC_P + 1);
   localparam int SCW = $clog2(START_CYC + 1);

   // ==========================================================
   // parameter checks
   if (DEB_CYC_P < 1 || FB_CYC_P < 1) begin : g_chk_min
      $error("debounce and feedback counts must be at least one");
   end
   // debounce plus sync must fit inside the beam response budget
   if (START_CYC > BEAM_RESP_CYC) begin : g_chk_resp
      $error("debounce too long for the beam response time");
   end
   if (FB_CYC_P > LOCK_RESP_CYC) begin : g_chk_fb
      $error("feedback settle longer than the lockout response");
   end

   // ==========================================================
   // state
   typedef struct packed {
      logic [NUM_IN-1:0] s1;
      logic [NUM_IN-1:0] s2;
      logic [NUM_IN-1:0] s3;
      logic [NUM_IN-1:0] filt;
      logic [NUM_IN-1:0][DCW-1:0] dcnt;
      logic [SCW-1:0] scnt;
      logic valid;
      logic lock;
      logic muted;
      logic [FCW-1:0] fcnt;
      logic fb_err;
      logic ext_cause;
      logic [CTRL_W-1:0] ctrl;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [1:0] safe;
      logic lock_out;
      logic monitor;
      logic emit;
      leds_s led;
   } state_s;

   state_s q;
   state_s n;
   logic test_stop;
   logic beam_eff;
   logic mismatch;
   logic out_on;
   logic [31:0] status;

   always_comb begin
      n = q;
      test_stop = 1'b0;
      beam_eff = 1'b0;
      mismatch = 1'b0;
      out_on = 1'b0;
      status = '0;
      status[SB_SAFE +: 2] = q.safe;
      status[SB_LOCK] = q.lock;
      status[SB_VALID] = q.valid;
      status[SB_MUTED] = q.muted;
      status[SB_FB_ERR] = q.fb_err;
      status[SB_EXT_CAUSE] = q.ext_cause;
      status[SB_IN_LSB +: NUM_IN] = q.filt;

      // =======================================================
      // apb: answer in the first access cycle; runs even when
      // CE_I is low so the bus never sees a stale ready
      n.pready = PSEL_I && !PENABLE_I;
      n.pslverr = 1'b0;
      n.prdata = '0;
      if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
         case (PADDR_I)
            ADDR_CTRL: n.prdata = 32'(q.ctrl);
            ADDR_STATUS: n.prdata = status;
            default: n.pslverr = 1'b1;
         endcase
      end else if (PSEL_I && !PENABLE_I) begin
         n.pslverr = (PADDR_I != ADDR_CTRL) && (PADDR_I != ADDR_STATUS);
      end
      if (PSEL_I && PENABLE_I && q.pready && PWRITE_I
          && PADDR_I == ADDR_CTRL && PSTRB_I[0]) begin
         n.ctrl = PWDATA_I[CTRL_W-1:0];
      end

      if (CE_I) begin
         // ====================================================
         // three-stage sync, then a change must hold for the
         // whole debounce window before it is believed
         n.s1 = CONTACT_I;
         n.s2 = q.s1;
         n.s3 = q.s2;
         for (int i = 0; i < NUM_IN; i++) begin
            if (q.s2[i] == q.s3[i] && q.s3[i] != q.filt[i]) begin
               if (q.dcnt[i] == DCW'(DEB_CYC_P - 1)) begin
                  n.filt[i] = q.s3[i];
                  n.dcnt[i] = '0;
               end else begin
                  n.dcnt[i] = q.dcnt[i] + 1'b1;
               end
            end else begin
               n.dcnt[i] = '0;
            end
         end
         if (!q.valid) begin
            if (q.scnt == SCW'(START_CYC - 1)) begin
               n.valid = 1'b1;
            end else begin
               n.scnt = q.scnt + 1'b1;
            end
         end

         // ====================================================
         // supervision
         test_stop = n.ctrl[CB_TEST] && !n.filt[IN_TEST];
         beam_eff = n.filt[IN_BEAM] && !test_stop;
         n.muted = n.ctrl[CB_MUTE] && n.filt[IN_MUTE_A]
                   && n.filt[IN_MUTE_B];
         mismatch = q.valid && (n.filt[IN_FB_A] != q.safe[0]
                    || n.filt[IN_FB_B] != q.safe[1]);
         // contactors need time to follow; only a lasting
         // disagreement counts
         if (mismatch) begin
            if (q.fcnt == FCW'(FB_CYC_P - 1)) begin
               n.fb_err = 1'b1;
            end else begin
               n.fcnt = q.fcnt + 1'b1;
            end
         end else begin
            n.fcnt = '0;
            n.fb_err = 1'b0;
         end
         n.ext_cause = n.valid && !n.filt[IN_EXTLOCK];
         // a present cause wins over a held release
         if (n.ext_cause || n.fb_err) begin
            n.lock = 1'b1;
         end else if (n.filt[IN_RELEASE]) begin
            n.lock = 1'b0;
         end

         out_on = n.valid && !n.lock
                  && !n.filt[IN_FORCEOFF]
                  && !(n.ctrl[CB_RESTART] && !n.filt[IN_RESTART])
                  && (n.muted
                      || (beam_eff && !n.filt[IN_FAULT]));
         n.safe = {2{out_on}};
         n.lock_out = !n.lock;
         n.emit = !test_stop;
         // monitor relay: 1 = contact closed = off state
         n.monitor = n.ctrl[CB_MONITOR] && (n.lock || !n.valid
                     || n.filt[IN_FAULT] || !beam_eff);
         if (n.ctrl[CB_TRI_LED] && n.lock) begin
            n.led = '1;
         end else begin
            n.led.power = 1'b1;
            n.led.beam = out_on;
            n.led.out_off = !out_on;
            n.led.lockout = n.lock;
         end
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         q <= '0;
         q.ctrl <= CTRL_RST;
      end else begin
         q <= n;
      end
   end

   assign PRDATA_O = q.prdata;
   assign PREADY_O = q.pready;
   assign PSLVERR_O = q.pslverr;
   assign SAFETY_OUT_O = q.safe;
   assign LOCKOUT_OUT_O = q.lock_out;
   assign MONITOR_OUT_O = q.monitor;
   assign EMIT_EN_O = q.emit;
   assign LED_O = q.led;

   // ==========================================================
   // checks
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (RST_I);

   a_lockout_relay_open: assert property (
      q.lock |-> !LOCKOUT_OUT_O && q.valid)
      else $error("lockout relay closed during lockout");
   a_monitor_beam_state: assert property (
      q.ctrl[CB_MONITOR] && q.valid && !q.lock && !q.filt[IN_FAULT]
      |-> MONITOR_OUT_O == !(q.filt[IN_BEAM] && q.emit))
      else $error("monitor relay does not follow beam");
   a_monitor_forced_off: assert property (
      q.ctrl[CB_MONITOR] && (q.lock || q.filt[IN_FAULT])
      |-> MONITOR_OUT_O)
      else $error("monitor relay not off on fault or lockout");
   a_release_clears: assert property (
      CE_I && q.lock && n.filt[IN_RELEASE] && !n.ext_cause
      && !n.fb_err |=> !q.lock)
      else $error("release did not leave lockout");
   a_ext_lock_enter: assert property (
      q.ext_cause |-> q.lock && !LOCKOUT_OUT_O)
      else $error("open external contact without lockout");
   a_forced_off_out: assert property (
      q.filt[IN_FORCEOFF] |-> SAFETY_OUT_O == 2'h0)
      else $error("safety outputs on while forced off");
   a_mute_both_chan: assert property (
      q.muted |-> q.filt[IN_MUTE_A] && q.filt[IN_MUTE_B]
      && q.ctrl[CB_MUTE])
      else $error("muted without both muting contacts");
   a_fb_settle_time: assert property (
      $rose(q.fb_err) |-> $past(q.fcnt) == FCW'(FB_CYC_P - 1)
      && q.lock)
      else $error("feedback lockout at wrong time");
   a_test_stop_emit: assert property (
      q.ctrl[CB_TEST] && !q.filt[IN_TEST] |-> !EMIT_EN_O
      && (q.muted || SAFETY_OUT_O == 2'h0))
      else $error("test input did not stop emission");
   a_restart_hold_off: assert property (
      q.ctrl[CB_RESTART] && !q.filt[IN_RESTART]
      |-> SAFETY_OUT_O == 2'h0)
      else $error("outputs on while restart open");
   a_led_lockout: assert property (
      q.lock |-> LED_O.lockout)
      else $error("lockout indicator dark in lockout");
   a_led_out_off: assert property (
      q.valid && !(q.lock && q.ctrl[CB_TRI_LED])
      |-> LED_O.out_off == (SAFETY_OUT_O == 2'h0))
      else $error("output-off indicator wrong");
   a_led_beam_on: assert property (
      q.valid && !q.lock |-> LED_O.beam == SAFETY_OUT_O[0])
      else $error("beam indicator wrong");
   a_led_all_lit: assert property (
      q.lock && q.ctrl[CB_TRI_LED] |-> LED_O == 4'hf)
      else $error("indicators not all lit in lockout");
   a_beam_loss_off: assert property (
      !q.muted && !q.filt[IN_BEAM] |-> SAFETY_OUT_O == 2'h0)
      else $error("outputs on with beam blocked");
   a_fault_off: assert property (
      !q.muted && q.filt[IN_FAULT] |-> SAFETY_OUT_O == 2'h0)
      else $error("outputs on with sensor fault");
   a_lock_exit_clean: assert property (
      $fell(q.lock) |-> q.filt[IN_RELEASE] && !q.ext_cause
      && !q.fb_err)
      else $error("lockout left without valid release");
   a_startup_off: assert property (
      !q.valid |-> SAFETY_OUT_O == 2'h0 ##1 !q.valid || $rose(q.valid))
      else $error("outputs on before inputs validated");
   a_lock_relay_closed: assert property (
      q.valid && !q.lock |-> LOCKOUT_OUT_O)
      else $error("lockout relay open in normal operation");
   a_muted_outputs_on: assert property (
      q.valid && q.muted && !q.lock && !q.filt[IN_FORCEOFF]
      && !(q.ctrl[CB_RESTART] && !q.filt[IN_RESTART])
      |-> SAFETY_OUT_O == 2'h3)
      else $error("muting did not hold outputs on");
   a_emit_normal: assert property (
      q.valid && !(q.ctrl[CB_TEST] && !q.filt[IN_TEST])
      |-> EMIT_EN_O)
      else $error("emission stopped without open test contact");
   a_lock_holds: assert property (
      q.lock && !n.filt[IN_RELEASE] |=> q.lock)
      else $error("lockout left without release");

   // ==========================================================
   // bus and enable checks
   // the bus keeps answering while supervision is frozen
   a_apb_one_wait: assert property (
      PSEL_I && !PENABLE_I |=> PREADY_O)
      else $error("apb ready missing in access cycle");
   a_apb_ready_pulse: assert property (
      PREADY_O |=> !PREADY_O)
      else $error("apb ready longer than one cycle");
   a_apb_err_ready: assert property (
      PSLVERR_O |-> PREADY_O)
      else $error("apb error without ready");
   a_apb_unmapped_err: assert property (
      PSEL_I && !PENABLE_I && PADDR_I != ADDR_CTRL
      && PADDR_I != ADDR_STATUS |=> PSLVERR_O && PRDATA_O == 32'h0)
      else $error("unmapped address not refused");
   a_ctrl_strobe_off: assert property (
      PSEL_I && PENABLE_I && PWRITE_I && !PSTRB_I[0] |=> $stable(q.ctrl))
      else $error("control written without byte strobe");
   a_ce_freeze: assert property (
      !CE_I |=> $stable(SAFETY_OUT_O) && $stable(LED_O)
      && $stable(q.lock) && $stable(q.filt))
      else $error("supervision state moved while disabled");

   c_ext_lockout: cover property ($rose(q.ext_cause));
   c_released: cover property ($fell(q.lock));
   c_muted_blocked: cover property (q.muted && !q.filt[IN_BEAM]
                                    && SAFETY_OUT_O == 2'h3);
   c_fb_lockout: cover property ($rose(q.fb_err));
   c_ce_frozen: cover property (!CE_I && SAFETY_OUT_O == 2'h3);

endmodule

// ---- tb/machine_model.sv ----
module machine_model (
   // clock and relay state
   input wire logic clk_i,
   input wire logic [1:0] safety_i,
   // behaviour
   input wire logic [1:0] lag_i,
   input wire logic stuck_i,
   // contactor feedback
   output logic [1:0] fb_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // contactors
   logic [1:0] hist_q [4] = '{default: 2'b00};

   always @(posedge clk_i) begin
      hist_q[0] <= safety_i;
      for (int i = 1; i < 4; i++) begin
         hist_q[i] <= hist_q[i-1];
      end
   end

   // slow contactors lag the relays; a welded or dead pair reads open
   assign fb_o = stuck_i ? 2'b00 :
      (lag_i == 2'd0) ? safety_i : hist_q[lag_i - 2'd1];
endmodule

// ---- tb/testbench.sv ----
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   n_mismatch++; $display("CHECK FAILED %s exp %h seen %h", nm, e, g); \
   end end

module testbench import safety_sup_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // signals
   localparam logic [8:0] NRM = 9'h189;
   logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic stuck = 0, tri_on = 1, pready, pslverr, lock_out, mon, emit;
   logic ce = 1;
   logic [3:0] strb = 4'hf;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [8:0] cn = NRM, exp_q[$];
   logic [32:0] rd_q[$];
   logic [1:0] safety, fb, lag = 0;
   leds_s leds;
   int n_mismatch = 0, n_checks = 0, seed = 32'h1b37;
   event obs_ev;

   always #2 mclk = ~mclk;

   light_curtain_safety_supervisor #(.DEB_CYC_P(4), .FB_CYC_P(16)) u_dut (
      .MCLK_I(mclk), .RST_I(rst), .CE_I(ce), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PSTRB_I(strb), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .CONTACT_I({fb, cn}),
      .SAFETY_OUT_O(safety), .LOCKOUT_OUT_O(lock_out),
      .MONITOR_OUT_O(mon), .EMIT_EN_O(emit), .LED_O(leds));

   machine_model u_machine (.clk_i(mclk), .safety_i(safety),
      .lag_i(lag), .stuck_i(stuck), .fb_o(fb));

   // ==========================================================
   // expectations and drivers
   function automatic logic [8:0] expv(input logic [8:0] c, input logic l);
      logic on;
      on = !l && !c[4] && c[8] && ((c[0] && !c[1] && c[7]) || (c[5] && c[6]));
      return {{2{on}}, !l, !c[0] || c[1] || !c[7] || l, c[7],
         (l && tri_on) ? 4'hf : {1'b1, on, !on, l}};
   endfunction

   // settle covers debounce plus feedback window with margin
   task automatic step(input logic [8:0] c, input logic l);
      cn <= c;
      lag <= 2'($unsigned($random(seed)) % 4);
      repeat (40) @(posedge mclk);
      exp_q.push_back(expv(c, l));
      @(negedge mclk);
      ->obs_ev;
      @(posedge mclk);
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      rd_q.push_back(e);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
      @(posedge mclk);
   endtask

   // ==========================================================
   // monitors
   always @(obs_ev) begin
      logic [8:0] ev;
      ev = exp_q.pop_front();
      `CHK("outputs", ev, {safety, lock_out, mon, emit, leds})
   end

   always @(posedge mclk) begin
      logic [32:0] rv;
      if (psel && penable && pready === 1'b1) begin
         rv = rd_q.pop_front();
         `CHK("apb", rv, {pslverr, pwrite ? 32'h0 : prdata})
      end
   end

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge mclk);
      n_mismatch++;
      final_report();
   end

   // ==========================================================
   // scenarios
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 0;
      apb(1, ADDR_CTRL, 32'h1f, 33'h0);
      apb(0, ADDR_CTRL, 0, {1'b0, 32'h1f});
      apb(0, 12'h100, 0, {1'b1, 32'h0});
      strb <= 4'h0;
      apb(1, ADDR_CTRL, 32'h0, 33'h0);
      strb <= 4'hf;
      apb(0, ADDR_CTRL, 0, {1'b0, 32'h1f});
      apb(1, ADDR_STATUS, $random(seed), 33'h0);
      step(NRM | 9'h4, 0);
      step(NRM, 0);
      step(NRM & ~9'h1, 0);
      step(NRM & ~9'h1 | 9'h60, 0);
      step(NRM & ~9'h1 | 9'h20, 0);
      step(NRM | 9'h2, 0);
      step(NRM & ~9'h80, 0);
      step(NRM & ~9'h100, 0);
      step(NRM | 9'h10, 0);
      cn <= NRM | 9'h10;
      repeat (2) @(posedge mclk);
      step(NRM, 0);
      step(NRM & ~9'h8, 1);
      apb(0, ADDR_STATUS, 0, {1'b0, 32'h0181004c});
      step(NRM & ~9'h8 | 9'h4, 1);
      step(NRM, 1);
      step(NRM | 9'h4, 0);
      step(NRM, 0);
      // frozen supervision must ignore a blocked beam
      ce <= 0;
      cn <= NRM & ~9'h1;
      repeat (40) @(posedge mclk);
      exp_q.push_back(expv(NRM, 0));
      @(negedge mclk);
      ->obs_ev;
      @(posedge mclk);
      ce <= 1;
      stuck <= 1;
      step(NRM, 1);
      stuck <= 0;
      step(NRM | 9'h4, 0);
      tri_on = 0;
      apb(1, ADDR_CTRL, 32'h0f, 33'h0);
      step(NRM & ~9'h8, 1);
      tri_on = 1;
      apb(1, ADDR_CTRL, 32'h1f, 33'h0);
      step(NRM & ~9'h8, 1);
      step(NRM | 9'h4, 0);
      final_report();
   end
endmodule
